// [srmc_ctrl.sv]
// mode state machine of the secondary-side synchronous rectifier
`timescale 1ns/10ps
`default_nettype none
module srmc_ctrl (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic vds_below_on_in,
	input wire logic vds_above_off_in,
	input wire logic drain_above_arm_in,
	input wire logic sync_low_in,
	input wire logic enable_above_on_in,
	input wire logic enable_below_off_in,
	input wire logic enable_zero_in,
	input wire logic supply_above_rise_in,
	input wire logic supply_below_fall_in,
	input wire logic temp_over_in,
	input wire logic temp_recovered_in,
	input wire logic [srmc_pkg::TMR_W-1:0] min_on_len,
	input wire logic [srmc_pkg::TMR_W-1:0] off_len,
	output logic gate_on,
	output logic thermal_flag_output,
	output logic enable_pulldown,
	output logic enable_start_current,
	output logic enable_run_current,
	output logic arm_flag,
	output srmc_pkg::srmc_mode_t mode
);
	// ----------------------------------------
	// synchronised comparator flags
	// ----------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] raw_flags;
	logic [NSYNC-1:0] s_flags;
	logic vds_on;
	logic vds_off;
	logic drain_arm;
	logic sync_low;
	logic en_on;
	logic en_off;
	logic en_zero;
	logic sup_ok;
	logic sup_low;
	logic t_over;
	logic t_rec;

	// comparators switch on their own analog timing, so every flag is resynchronised
	assign raw_flags = {
		vds_below_on_in,
		vds_above_off_in,
		drain_above_arm_in,
		sync_low_in,
		enable_above_on_in,
		enable_below_off_in,
		enable_zero_in,
		supply_above_rise_in,
		supply_below_fall_in,
		temp_over_in,
		temp_recovered_in
	};

	srmc_sync2 #(.W(NSYNC)) u_sync (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.async_in(raw_flags),
		.sync_out(s_flags)
	);

	assign vds_on = s_flags[10];
	assign vds_off = s_flags[9];
	assign drain_arm = s_flags[8];
	assign sync_low = s_flags[7];
	assign en_on = s_flags[6];
	assign en_off = s_flags[5];
	assign en_zero = s_flags[4];
	assign sup_ok = s_flags[3];
	assign sup_low = s_flags[2];
	assign t_over = s_flags[1];
	assign t_rec = s_flags[0];

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		srmc_pkg::srmc_mode_t mode;
		logic gate;
		logic arm;
		logic early_off;
		logic skip_next;
		logic long_on;
		logic cond_seen;
		logic diode_long;
		logic drain_hi;
		logic sync_prev;
		logic supply_lockout;
		logic therm;
		logic run_cur;
		// power-up interval counted in core clocks
		logic [10:0] pup;
	} srmc_st_t;

	srmc_st_t st_q;
	srmc_st_t st_d;

	logic on_start;
	logic on_clear;
	logic on_run;
	logic off_start;
	logic off_run;
	logic sync_fall;
	logic drain_rise;
	logic turn_on;
	logic turn_off;

	assign sync_fall = sync_low & ~st_q.sync_prev;
	assign drain_rise = drain_arm & ~st_q.drain_hi;

	// ----------------------------------------
	// timers
	// ----------------------------------------
	srmc_timer u_min_on (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(on_start),
		.clear(on_clear),
		.load_val(min_on_len),
		.running(on_run),
		.expired()
	);

	srmc_timer u_off (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.start(off_start),
		.clear(on_clear),
		.load_val(off_len),
		.running(off_run),
		.expired()
	);

	// ----------------------------------------
	// switching cycle decisions
	// ----------------------------------------
	function automatic logic is_light(input srmc_pkg::srmc_mode_t m);
		is_light = (m == srmc_pkg::SRMC_LIGHT);
	endfunction

	function automatic logic is_active(input srmc_pkg::srmc_mode_t m);
		is_active = (m == srmc_pkg::SRMC_ACTIVE);
	endfunction

	function automatic logic in_run(input srmc_pkg::srmc_mode_t m);
		in_run = is_light(m) || is_active(m);
	endfunction

	always_comb begin
		off_start = in_run(st_q.mode) && (sync_fall || drain_rise);
		// sensing is masked while the off timer runs, and in its start cycle
		turn_on = is_active(st_q.mode)
			&& st_q.long_on
			&& !st_q.gate
			&& st_q.arm
			&& !off_run
			&& !off_start
			&& vds_on
			&& !sync_low
			&& !st_q.supply_lockout
			&& !st_q.skip_next;
		// min-on masks vds but never the sync pulse
		turn_off = st_q.gate
			&& (sync_low
			|| st_q.supply_lockout
			|| (!on_run && vds_off));
	end

	always_comb begin
		st_d = st_q;
		on_clear = 1'b0;
		on_start = turn_on;
		st_d.sync_prev = sync_low;
		st_d.drain_hi = drain_arm;

		// ----------------------------------------
		// supply lockout and thermal flag
		// ----------------------------------------
		// lockout set wins over recovery, so a brown-out is never missed
		if (sup_low) begin
			st_d.supply_lockout = 1'b1;
		end else if (sup_ok) begin
			st_d.supply_lockout = 1'b0;
		end

		// thermal flag: set wins over recovery
		if (t_over) begin
			st_d.therm = 1'b1;
		end else if (t_rec) begin
			st_d.therm = 1'b0;
		end

		// ----------------------------------------
		// arming and gate drive
		// ----------------------------------------
		// arming: drain above arming level while off in light-load or active mode
		if (turn_on) begin
			st_d.arm = 1'b0;
		end else if (drain_arm && !st_q.gate && in_run(st_q.mode)) begin
			st_d.arm = 1'b1;
		end

		if (turn_on) begin
			st_d.gate = 1'b1;
			st_d.early_off = 1'b0;
			st_d.skip_next = 1'b0;
		end else if (turn_off) begin
			st_d.gate = 1'b0;
			st_d.long_on = !on_run;
		end

		// a turn-off level inside min-on is masked, it only marks the cycle as short
		if (st_q.gate && on_run && vds_off) begin
			st_d.early_off = 1'b1;
		end

		// ----------------------------------------
		// light-load: body-diode conduction timed by min-on
		// ----------------------------------------
		if (is_light(st_q.mode) && !st_q.gate) begin
			if (vds_on && !st_q.cond_seen && st_q.arm && !off_run) begin
				st_d.cond_seen = 1'b1;
				on_start = 1'b1;
			end else if (st_q.cond_seen && !vds_on) begin
				st_d.cond_seen = 1'b0;
				st_d.diode_long = !on_run;
			end
		end

		// ----------------------------------------
		// cycle boundary at the drain rise
		// ----------------------------------------
		if (drain_rise && in_run(st_q.mode)) begin
			st_d.skip_next = 1'b0;
			st_d.cond_seen = 1'b0;
			if (is_light(st_q.mode) && st_q.diode_long) begin
				st_d.mode = srmc_pkg::SRMC_ACTIVE;
				st_d.long_on = 1'b1;
				st_d.diode_long = 1'b0;
			end else if (is_active(st_q.mode) && (st_q.early_off || !st_q.long_on)) begin
				st_d.mode = srmc_pkg::SRMC_LIGHT;
				st_d.skip_next = st_q.early_off;
				st_d.early_off = 1'b0;
			end
		end

		// ----------------------------------------
		// mode sequencing
		// ----------------------------------------
		case (st_q.mode)
			srmc_pkg::SRMC_SLEEP: begin
				if (!st_q.supply_lockout && en_on) begin
					st_d.mode = srmc_pkg::SRMC_POWERUP;
					st_d.pup = srmc_pkg::PUP_LOAD;
				end
			end
			srmc_pkg::SRMC_POWERUP: begin
				if (st_q.pup == srmc_pkg::PUP_ONE || st_q.pup == srmc_pkg::PUP_ZERO) begin
					st_d.mode = srmc_pkg::SRMC_LIGHT;
					st_d.run_cur = 1'b1;
					st_d.pup = srmc_pkg::PUP_ZERO;
				end else begin
					st_d.pup = st_q.pup - srmc_pkg::PUP_ONE;
				end
			end
			srmc_pkg::SRMC_LIGHT: begin
			end
			srmc_pkg::SRMC_ACTIVE: begin
			end
			default: begin
				st_d.mode = srmc_pkg::SRMC_SLEEP;
			end
		endcase

		// ----------------------------------------
		// sleep entry
		// ----------------------------------------
		// sleep entry overrides everything: lockout, low enable, or enable at zero
		if (st_q.supply_lockout || en_off || en_zero) begin
			st_d.mode = srmc_pkg::SRMC_SLEEP;
			st_d.gate = 1'b0;
			st_d.arm = 1'b0;
			st_d.early_off = 1'b0;
			st_d.skip_next = 1'b0;
			st_d.long_on = 1'b0;
			st_d.cond_seen = 1'b0;
			st_d.diode_long = 1'b0;
			st_d.run_cur = 1'b0;
			st_d.pup = srmc_pkg::PUP_ZERO;
			on_clear = 1'b1;
		end
	end

	// lockout is assumed at reset until the supply comparator reports good
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '{mode: srmc_pkg::SRMC_SLEEP, supply_lockout: 1'b1, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign gate_on = st_q.gate;
	assign thermal_flag_output = st_q.therm;
	// both sources stay off in lockout while the pull-down holds the pin
	assign enable_pulldown = st_q.supply_lockout;
	assign enable_start_current = !st_q.supply_lockout && !st_q.run_cur;
	assign enable_run_current = !st_q.supply_lockout && st_q.run_cur;
	assign arm_flag = st_q.arm;
	assign mode = st_q.mode;
endmodule
`default_nettype wire

// [srmc_ctrl_props.sv]
// checker: timing properties on the mode control ports
`timescale 1ns/10ps
`default_nettype none
module srmc_ctrl_props (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sync_low_in,
	input wire logic enable_zero_in,
	input wire logic supply_below_fall_in,
	input wire logic temp_over_in,
	input wire logic temp_recovered_in,
	input wire logic gate_on,
	input wire logic thermal_flag_output,
	input wire logic enable_pulldown,
	input wire logic enable_start_current,
	input wire logic enable_run_current,
	input wire logic arm_flag,
	input wire srmc_pkg::srmc_mode_t mode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// three samples cover the two-flop synchroniser plus the decision edge
	sequence s_held3(x);
		x [*3];
	endsequence
	a_reset_state: assert property (disable iff (1'b0)
		sys_rst |=> mode == srmc_pkg::SRMC_SLEEP && !gate_on && !arm_flag) else $error("reset state wrong");
	a_sync_off: assert property (
		s_held3(sync_low_in) |=> !gate_on) else $error("gate on while sync low");
	a_zero_sleep: assert property (
		s_held3(enable_zero_in) |=> mode == srmc_pkg::SRMC_SLEEP) else $error("no sleep at zero enable");
	a_lockout_off: assert property (
		s_held3(supply_below_fall_in) |=> !gate_on && enable_pulldown) else $error("lockout not applied");
	a_temp_set: assert property (
		s_held3(temp_over_in) |=> thermal_flag_output) else $error("thermal flag not set");
	a_temp_hold: assert property (
		(!temp_recovered_in) [*4] |-> !$fell(thermal_flag_output)) else $error("thermal flag cleared early");
	a_arm_clear: assert property (
		$rose(gate_on) |-> $past(arm_flag) && !arm_flag) else $error("turn-on without arm");
	a_on_active: assert property (
		$rose(gate_on) |-> mode == srmc_pkg::SRMC_ACTIVE) else $error("turn-on outside active");
	a_sleep_off: assert property (
		mode inside {srmc_pkg::SRMC_SLEEP, srmc_pkg::SRMC_POWERUP} |-> !gate_on) else $error("gate on in sleep");
	a_pull_excl: assert property (
		enable_pulldown |-> !enable_start_current && !enable_run_current) else $error("pull-down with source");
endmodule
bind srmc_ctrl srmc_ctrl_props u_props (.core_clk, .sys_rst, .sync_low_in, .enable_zero_in, .supply_below_fall_in,
	.temp_over_in, .temp_recovered_in, .gate_on, .thermal_flag_output, .enable_pulldown, .enable_start_current,
	.enable_run_current, .arm_flag, .mode);
`default_nettype wire

// [srmc_ctrl_tb.sv]
// self-checking bench for the sync rectifier mode control
`timescale 1ns/10ps
`default_nettype none
module srmc_ctrl_tb;
	localparam logic [11:0] MIN_ON = 12'h0_010;
	localparam logic [11:0] OFF_LEN = 12'h0_006;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic vds_below_on_in = 1'b0, vds_above_off_in = 1'b0, drain_above_arm_in = 1'b0, prim_fire = 1'b0;
	logic enable_above_on_in = 1'b0, enable_below_off_in = 1'b1, enable_zero_in = 1'b1;
	logic supply_above_rise_in = 1'b0, supply_below_fall_in = 1'b1, temp_over_in = 1'b0, temp_recovered_in = 1'b0;
	logic gate_on, thermal_flag_output, enable_pulldown, enable_start_current, enable_run_current, arm_flag;
	wire sync_low_in;
	srmc_pkg::srmc_mode_t mode;
	int errors = 0, check_count = 0, n, i, on_len;
	always #12.5 core_clk = ~core_clk;
	srmc_primary_model u_prim (.core_clk, .gate_fire(prim_fire), .sync_low(sync_low_in));
	srmc_ctrl u_dut (.core_clk, .sys_rst, .vds_below_on_in, .vds_above_off_in, .drain_above_arm_in, .sync_low_in,
		.enable_above_on_in, .enable_below_off_in, .enable_zero_in, .supply_above_rise_in, .supply_below_fall_in,
		.temp_over_in, .temp_recovered_in, .min_on_len(MIN_ON), .off_len(OFF_LEN), .gate_on, .thermal_flag_output,
		.enable_pulldown, .enable_start_current, .enable_run_current, .arm_flag, .mode);
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic wait_mode(input srmc_pkg::srmc_mode_t m, input int lim);
		for (n = 0; n < lim && mode !== m; n++) begin
			@(negedge core_clk);
		end
		chk("mode", mode, m);
	endtask
	// one switching period: drain rise arms, then body-diode conduction, then the turn-off level;
	// glitch puts a short turn-off level pulse inside the conduction phase
	task automatic sw_cycle(input int cond, input int cut, input int glitch = 99);
		@(posedge core_clk) drain_above_arm_in <= 1'b1;
		repeat (2) @(posedge core_clk);
		drain_above_arm_in <= 1'b0;
		vds_below_on_in <= 1'b1;
		on_len = 0;
		for (i = 0; i < cond; i++) begin
			@(negedge core_clk) on_len += int'(gate_on === 1'b1);
			@(posedge core_clk) prim_fire <= (i == cut);
			if (i == glitch || i == glitch + 2) begin
				vds_above_off_in <= (i == glitch);
			end
		end
		vds_below_on_in <= 1'b0;
		vds_above_off_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		vds_above_off_in <= 1'b0;
		@(negedge core_clk) chk("gate_off", gate_on, 1'b0);
	endtask
	task automatic t_reset;
		chk("mode", mode, srmc_pkg::SRMC_SLEEP);
		chk("gate", gate_on, 1'b0);
		chk("arm", arm_flag, 1'b0);
		chk("pulldown", enable_pulldown, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_powerup;
		@(posedge core_clk) supply_above_rise_in <= 1'b1;
		supply_below_fall_in <= 1'b0;
		repeat (5) @(negedge core_clk);
		chk("pulldown", enable_pulldown, 1'b0);
		chk("start_cur", enable_start_current, 1'b1);
		@(posedge core_clk) enable_above_on_in <= 1'b1;
		enable_below_off_in <= 1'b0;
		enable_zero_in <= 1'b0;
		wait_mode(srmc_pkg::SRMC_POWERUP, 8);
		wait_mode(srmc_pkg::SRMC_LIGHT, 1100);
		chk("powerup_len", n >= 998 && n <= 1002, 1'b1);
		chk("run_cur", enable_run_current, 1'b1);
		chk("start_cur", enable_start_current, 1'b0);
		$display("test powerup done");
	endtask
	task automatic t_modes;
		sw_cycle(4, -1);
		chk("mode", mode, srmc_pkg::SRMC_LIGHT);
		chk("light_on", on_len, 0);
		sw_cycle(40, -1);
		chk("light_on", on_len, 0);
		sw_cycle(40, -1);
		chk("mode", mode, srmc_pkg::SRMC_ACTIVE);
		chk("long_on", on_len > int'(MIN_ON), 1'b1);
		chk("off_block", on_len <= 40 - int'(OFF_LEN), 1'b1);
		chk("arm", arm_flag, 1'b0);
		sw_cycle(40, -1);
		chk("mode", mode, srmc_pkg::SRMC_ACTIVE);
		$display("test modes done");
	endtask
	// the sync cut lands well inside min-on, so the on-time must come out short
	task automatic t_sync;
		sw_cycle(40, 12);
		chk("cut_on", on_len > 0 && on_len < int'(MIN_ON), 1'b1);
		sw_cycle(40, -1);
		chk("mode", mode, srmc_pkg::SRMC_LIGHT);
		chk("skip_on", on_len, 0);
		$display("test sync done");
	endtask
	// a turn-off level inside min-on is masked but sends the next cycle to light-load
	task automatic t_early;
		sw_cycle(40, -1, 10);
		chk("mode", mode, srmc_pkg::SRMC_ACTIVE);
		chk("masked_on", on_len > int'(MIN_ON), 1'b1);
		sw_cycle(40, -1);
		chk("mode", mode, srmc_pkg::SRMC_LIGHT);
		chk("skip_on", on_len, 0);
		$display("test early done");
	endtask
	task automatic t_temp;
		@(posedge core_clk) temp_over_in <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("thermal", thermal_flag_output, 1'b1);
		@(posedge core_clk) temp_over_in <= 1'b0;
		repeat (8) @(negedge core_clk);
		chk("thermal", thermal_flag_output, 1'b1);
		@(posedge core_clk) temp_recovered_in <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("thermal", thermal_flag_output, 1'b0);
		$display("test thermal done");
	endtask
	task automatic t_sleep;
		@(posedge core_clk) enable_above_on_in <= 1'b0;
		enable_below_off_in <= 1'b1;
		enable_zero_in <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("mode", mode, srmc_pkg::SRMC_SLEEP);
		@(posedge core_clk) supply_above_rise_in <= 1'b0;
		supply_below_fall_in <= 1'b1;
		repeat (5) @(negedge core_clk);
		chk("pulldown", enable_pulldown, 1'b1);
		@(posedge core_clk) supply_above_rise_in <= 1'b1;
		supply_below_fall_in <= 1'b0;
		repeat (5) @(negedge core_clk);
		chk("pulldown", enable_pulldown, 1'b0);
		$display("test sleep done");
	endtask
	initial begin
		repeat (2) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(negedge core_clk);
		t_reset;
		t_powerup;
		t_modes;
		t_sync;
		t_early;
		t_temp;
		t_sleep;
		wrap_up;
	end
	// whole run needs about 1400 cycles, mostly the power-up wait
	initial begin
		repeat (6000) @(posedge core_clk);
		errors++;
		$display("[FAIL] watchdog expected finish seen hang");
		wrap_up;
	end
endmodule
`default_nettype wire

// [srmc_pkg.sv]
// package: constants and state types of the sync rectifier mode control
package srmc_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int POWERUP_US = 25;
	localparam int POWERUP_CYC = POWERUP_US * CLK_MHZ;
	localparam int TMR_W = 12;
	localparam logic [TMR_W-1:0] MIN_ON_DEF = 12'h0_00E;
	localparam logic [TMR_W-1:0] OFF_DEF = 12'h0_014;
	localparam logic [TMR_W-1:0] TMR_ZERO = 12'h0_000;
	localparam logic [TMR_W-1:0] TMR_ONE = 12'h0_001;
	localparam logic [10:0] PUP_LOAD = 11'(POWERUP_CYC);
	localparam logic [10:0] PUP_ZERO = 11'h000;
	localparam logic [10:0] PUP_ONE = 11'h001;

	// ----------------------------------------
	// modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRMC_SLEEP,
		SRMC_POWERUP,
		SRMC_LIGHT,
		SRMC_ACTIVE
	} srmc_mode_t;
endpackage

// [srmc_primary_model.sv]
// primary-side controller model: pulls the sync pin low on each gate turn-on
`timescale 1ns/10ps
`default_nettype none
module srmc_primary_model #(
	parameter int PULSE_CYC = 4
) (
	input wire logic core_clk,
	input wire logic gate_fire,
	output logic sync_low
);
	int cnt_q = 0;
	// pin is always driven; idle means the pulled-up level, never left floating
	assign sync_low = (cnt_q != 0);
	always @(posedge core_clk) begin
		if (gate_fire) begin
			cnt_q <= PULSE_CYC;
		end else if (cnt_q != 0) begin
			cnt_q <= cnt_q - 1;
		end
	end
endmodule
`default_nettype wire

// [srmc_sync2.sv]
// two-flop synchroniser for a group of comparator flags
`timescale 1ns/10ps
`default_nettype none
module srmc_sync2 #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} srmc_sync_st_t;

	srmc_sync_st_t st_q;
	srmc_sync_st_t st_d;

	// first stage feeds only the second
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_in;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_out = st_q.s2;
endmodule
`default_nettype wire

// [srmc_timer.sv]
// loadable down counter used for the min-on and off timers
`timescale 1ns/10ps
`default_nettype none
module srmc_timer (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic clear,
	input wire logic [srmc_pkg::TMR_W-1:0] load_val,
	output logic running,
	output logic expired
);
	typedef struct packed {
		logic [srmc_pkg::TMR_W-1:0] cnt;
		logic exp;
	} srmc_tmr_st_t;

	srmc_tmr_st_t st_q;
	srmc_tmr_st_t st_d;

	always_comb begin
		st_d = st_q;
		st_d.exp = 1'b0;
		if (clear) begin
			st_d.cnt = srmc_pkg::TMR_ZERO;
		end else if (start) begin
			// a zero length still runs one cycle
			st_d.cnt = (load_val == srmc_pkg::TMR_ZERO) ? srmc_pkg::TMR_ONE : load_val;
		end else if (st_q.cnt != srmc_pkg::TMR_ZERO) begin
			st_d.cnt = st_q.cnt - srmc_pkg::TMR_ONE;
			st_d.exp = (st_q.cnt == srmc_pkg::TMR_ONE);
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign running = (st_q.cnt != srmc_pkg::TMR_ZERO);
	assign expired = st_q.exp;
endmodule
`default_nettype wire
